// ===== ifw_defs.svh
`ifndef IFW_DEFS_SVH
`define IFW_DEFS_SVH

// =====================================================================
// Identify word indices (byte address is four times the index)
`define IFW_IDX_W75     10'd75
`define IFW_IDX_W82     10'd82
`define IFW_IDX_W83     10'd83
`define IFW_IDX_W84     10'd84
`define IFW_IDX_W85     10'd85
`define IFW_IDX_W86     10'd86
`define IFW_IDX_W87     10'd87
`define IFW_IDX_W88     10'd88
`define IFW_IDX_W89     10'd89
`define IFW_IDX_W92     10'd92
`define IFW_IDX_W100    10'd100
`define IFW_IDX_W101    10'd101
`define IFW_IDX_W102    10'd102
`define IFW_IDX_W103    10'd103
`define IFW_IDX_W128    10'd128
`define IFW_IDX_W209    10'd209
`define IFW_IDX_W217    10'd217

// =====================================================================
// Configuration register indices
`define IFW_IDX_CTRL    10'd256
`define IFW_IDX_SEC     10'd257
`define IFW_IDX_DMA     10'd258
`define IFW_IDX_ERASE   10'd259
`define IFW_IDX_MPWREV  10'd260
`define IFW_IDX_LBA_LO  10'd261
`define IFW_IDX_LBA_HI  10'd262
`define IFW_IDX_ALIGN   10'd263
`define IFW_IDX_QDEPTH  10'd264

// =====================================================================
// Control field positions
`define IFW_CTRL_SEC_SUP   0
`define IFW_CTRL_WC_SUP    1
`define IFW_CTRL_LA_SUP    2
`define IFW_CTRL_PWR_SUP   3
`define IFW_CTRL_UDMA_SUP  4
`define IFW_CTRL_ENH_SUP   5
`define IFW_CTRL_WC_EN     6
`define IFW_CTRL_LA_EN     7
`define IFW_CTRL_PWR_EN    8
`define IFW_CTRL_QUEUE_SUP 9
`define IFW_CTRL_MULTI     10
`define IFW_CTRL_W         11
// Security field positions
`define IFW_SEC_PW_SET     0
`define IFW_SEC_LOCKED     1
`define IFW_SEC_FROZEN     2
`define IFW_SEC_LVL_MAX    3
`define IFW_SEC_EXPIRED    4
`define IFW_SEC_W          5

// =====================================================================
// Fixed word contents and reset values
`define IFW_W82_FIXED   16'h7408
`define IFW_W83_FIXED   16'h4001
`define IFW_W84_FIXED   16'h4000
`define IFW_W85_FIXED   16'h7008
`define IFW_W86_FIXED   16'h0001
`define IFW_W87_FIXED   16'h4000
`define IFW_W217_FIXED  16'h0001
`define IFW_CTRL_RST    11'h037
`define IFW_SEC_RST     5'h00
`define IFW_DMA_RST     8'h06
`define IFW_ERASE_RST   16'h0000
`define IFW_MPWREV_RST  16'hFFFF
`define IFW_LBA_RST     48'h0000_0000_0000
`define IFW_LBA_MAX     48'hFFFF_FFFF_FFFF
`define IFW_ALIGN_RST   14'h0000
`define IFW_QDEPTH_RST  5'h00

`endif

// ===== ifw_pkg.sv
package ifw_pkg;
  typedef logic [15:0] ifw_word_t;
  typedef logic [9:0]  ifw_idx_t;
  typedef logic [2:0]  ifw_mode_t;
endpackage : ifw_pkg

// ===== ifw_feature_words.sv
`include "ifw_defs.svh"

module ifw_feature_words (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              assemble_i,
  input  wire logic              unlock_fail_limit_i,
  output logic                   unlock_abort_o,
  output logic                   mwdma_selected_o
);
  import ifw_pkg::*;

  // ===================================================================
  // Bus decode
  wire ifw_idx_t idx     = wb_adr_i[11:2];
  wire logic     req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands on the ack edge, while the master still holds address and data
  wire logic     wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire logic     wr_ctrl = wr && (idx == `IFW_IDX_CTRL);
  wire logic     wr_sec  = wr && (idx == `IFW_IDX_SEC);
  wire logic     wr_dma  = wr && (idx == `IFW_IDX_DMA);
  wire logic     wr_era  = wr && (idx == `IFW_IDX_ERASE);
  wire logic     wr_mpw  = wr && (idx == `IFW_IDX_MPWREV);
  wire logic     wr_llo  = wr && (idx == `IFW_IDX_LBA_LO);
  wire logic     wr_lhi  = wr && (idx == `IFW_IDX_LBA_HI);
  wire logic     wr_aln  = wr && (idx == `IFW_IDX_ALIGN);
  wire logic     wr_qd   = wr && (idx == `IFW_IDX_QDEPTH);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ===================================================================
  // Configuration registers
  logic [`IFW_CTRL_W-1:0] ctrl;
  logic [`IFW_SEC_W-1:0]  sec;
  logic [7:0]             dma;
  logic [15:0]            erase_time;
  logic [15:0]            mpw_rev;
  logic [47:0]            max_lba;
  logic [13:0]            align;
  logic [4:0]             qdepth;

  wire logic [31:0] m_ctrl = merge({21'h0, ctrl}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_sec  = merge({27'h0, sec}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_dma  = merge({24'h0, dma}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_era  = merge({16'h0, erase_time}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_mpw  = merge({16'h0, mpw_rev}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_llo  = merge(max_lba[31:0], wb_dat_i, wb_sel_i);
  wire logic [31:0] m_lhi  = merge({16'h0, max_lba[47:32]}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_aln  = merge({18'h0, align}, wb_dat_i, wb_sel_i);
  wire logic [31:0] m_qd   = merge({27'h0, qdepth}, wb_dat_i, wb_sel_i);

  // Expired flag: reset clears it even during a set, and software can never clear it
  wire logic expire_set  = unlock_fail_limit_i;
  wire logic next_expire = sec[`IFW_SEC_EXPIRED] || expire_set;
  wire logic [`IFW_SEC_W-1:0] next_sec = wr_sec ? {next_expire, m_sec[3:0]}
                                                : {next_expire, sec[3:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl       <= `IFW_CTRL_RST;
      sec        <= `IFW_SEC_RST;
      dma        <= `IFW_DMA_RST;
      erase_time <= `IFW_ERASE_RST;
      mpw_rev    <= `IFW_MPWREV_RST;
      max_lba    <= `IFW_LBA_RST;
      align      <= `IFW_ALIGN_RST;
      qdepth     <= `IFW_QDEPTH_RST;
    end else begin
      if (wr_ctrl) ctrl <= m_ctrl[`IFW_CTRL_W-1:0];
      sec <= next_sec;
      if (wr_dma) dma <= m_dma[7:0];
      if (wr_era) erase_time <= m_era[15:0];
      if (wr_mpw) mpw_rev <= m_mpw[15:0];
      if (wr_llo) max_lba[31:0] <= m_llo;
      if (wr_lhi) max_lba[47:32] <= m_lhi[15:0];
      if (wr_aln) align <= m_aln[13:0];
      if (wr_qd) qdepth <= m_qd[4:0];
    end
  end

  assign unlock_abort_o = sec[`IFW_SEC_EXPIRED];

  // ===================================================================
  // Snapshot of dynamic state at identify assembly
  logic [`IFW_CTRL_W-1:0] snap_ctrl;
  logic [`IFW_SEC_W-1:0]  snap_sec;
  logic [7:0]             snap_dma;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_ctrl <= `IFW_CTRL_RST;
      snap_sec  <= `IFW_SEC_RST;
      snap_dma  <= `IFW_DMA_RST;
    end else if (assemble_i) begin
      snap_ctrl <= ctrl;
      snap_sec  <= sec;
      snap_dma  <= dma;
    end
  end

  // ===================================================================
  // Word assembly
  wire logic sec_sup  = snap_ctrl[`IFW_CTRL_SEC_SUP];
  wire logic wc_sup   = snap_ctrl[`IFW_CTRL_WC_SUP];
  wire logic la_sup   = snap_ctrl[`IFW_CTRL_LA_SUP];
  wire logic pwr_sup  = snap_ctrl[`IFW_CTRL_PWR_SUP];
  wire logic udma_sup = snap_ctrl[`IFW_CTRL_UDMA_SUP];
  wire logic sec_en   = sec_sup && snap_sec[`IFW_SEC_PW_SET];
  wire logic wc_en    = wc_sup && snap_ctrl[`IFW_CTRL_WC_EN];
  wire logic la_en    = la_sup && snap_ctrl[`IFW_CTRL_LA_EN];
  wire logic pwr_en   = pwr_sup && snap_ctrl[`IFW_CTRL_PWR_EN];

  // Mode field: [2:0] highest supported, [5:3] selected, [6] ultra sel, [7] multiword sel
  wire ifw_mode_t udma_max  = snap_dma[2:0];
  wire ifw_mode_t udma_sel  = snap_dma[5:3];
  // Ultra selection only when supported and not beyond max; wins over multiword
  wire logic      udma_act  = udma_sup && snap_dma[6] && (udma_sel <= udma_max) && (udma_sel != 3'd7);
  wire logic      mw_act    = snap_dma[7] && !udma_act;
  assign mwdma_selected_o = mw_act;

  function automatic logic [6:0] cum_mask(input ifw_mode_t m);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < 7; i++) begin
      if (i <= int'(m)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : cum_mask

  wire logic [6:0] sel_hot = udma_act ? (7'h01 << udma_sel) : 7'h00;
  wire logic [6:0] sup_cum = cum_mask(udma_max);
  wire ifw_word_t w88 = udma_sup ? {1'b0, sel_hot, 1'b0, sup_cum} : 16'h0000;

  wire ifw_word_t w82 = `IFW_W82_FIXED | {9'h0, la_sup, wc_sup, 3'h0, sec_sup, 1'b0};
  wire ifw_word_t w83 = `IFW_W83_FIXED | {12'h0, pwr_sup, 3'h0};
  wire ifw_word_t w84 = `IFW_W84_FIXED;
  wire ifw_word_t w85 = `IFW_W85_FIXED | {9'h0, la_en, wc_en, 3'h0, sec_en, 1'b0};
  wire ifw_word_t w86 = `IFW_W86_FIXED | {12'h0, pwr_en, 3'h0};
  wire ifw_word_t w87 = `IFW_W87_FIXED;
  wire ifw_word_t w75 = snap_ctrl[`IFW_CTRL_QUEUE_SUP] ? {11'h0, qdepth} : 16'h0000;
  wire ifw_word_t w128 = {7'h0, sec_en && snap_sec[`IFW_SEC_LVL_MAX], 2'h0,
                          snap_ctrl[`IFW_CTRL_ENH_SUP], snap_sec[`IFW_SEC_EXPIRED],
                          snap_sec[`IFW_SEC_FROZEN], snap_sec[`IFW_SEC_LOCKED], sec_en, sec_sup};
  wire ifw_word_t w209 = snap_ctrl[`IFW_CTRL_MULTI] ? {2'b00, align} : 16'h0000;
  wire logic [47:0] cap = (max_lba == `IFW_LBA_MAX) ? max_lba : max_lba + 48'h0000_0000_0001;

  // ===================================================================
  // Read mux
  function automatic logic [31:0] rd_word(input ifw_idx_t a);
    case (a)
      `IFW_IDX_W75:     rd_word = {16'h0, w75};
      `IFW_IDX_W82:     rd_word = {16'h0, w82};
      `IFW_IDX_W83:     rd_word = {16'h0, w83};
      `IFW_IDX_W84:     rd_word = {16'h0, w84};
      `IFW_IDX_W85:     rd_word = {16'h0, w85};
      `IFW_IDX_W86:     rd_word = {16'h0, w86};
      `IFW_IDX_W87:     rd_word = {16'h0, w87};
      `IFW_IDX_W88:     rd_word = {16'h0, w88};
      `IFW_IDX_W89:     rd_word = {16'h0, erase_time};
      `IFW_IDX_W92:     rd_word = {16'h0, mpw_rev};
      `IFW_IDX_W100:    rd_word = {16'h0, cap[15:0]};
      `IFW_IDX_W101:    rd_word = {16'h0, cap[31:16]};
      `IFW_IDX_W102:    rd_word = {16'h0, cap[47:32]};
      `IFW_IDX_W103:    rd_word = 32'h0000_0000;
      `IFW_IDX_W128:    rd_word = {16'h0, w128};
      `IFW_IDX_W209:    rd_word = {16'h0, w209};
      `IFW_IDX_W217:    rd_word = {16'h0, `IFW_W217_FIXED};
      `IFW_IDX_CTRL:    rd_word = {21'h0, ctrl};
      `IFW_IDX_SEC:     rd_word = {27'h0, sec};
      `IFW_IDX_DMA:     rd_word = {24'h0, dma};
      `IFW_IDX_ERASE:   rd_word = {16'h0, erase_time};
      `IFW_IDX_MPWREV:  rd_word = {16'h0, mpw_rev};
      `IFW_IDX_LBA_LO:  rd_word = max_lba[31:0];
      `IFW_IDX_LBA_HI:  rd_word = {16'h0, max_lba[47:32]};
      `IFW_IDX_ALIGN:   rd_word = {18'h0, align};
      `IFW_IDX_QDEPTH:  rd_word = {27'h0, qdepth};
      default:          rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  wire logic [31:0] next_dat = rd_word(idx);

  // One wait state: data and ack registered together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? next_dat : 32'h0000_0000;
    end
  end

  // ===================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire logic rd_ack = wb_ack_o && !wb_we_i;

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack;
    s_req |=> s_ack_once;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");

  property p_valid_words;
    rd_ack && (idx == `IFW_IDX_W83 || idx == `IFW_IDX_W84) |-> wb_dat_o[15:14] == 2'b01;
  endproperty
  a_valid_words: assert property (p_valid_words) else $error("word 83/84 validity bits wrong");

  property p_w82;
    rd_ack && idx == `IFW_IDX_W82 |-> (wb_dat_o[15:0] & 16'hFF9F & ~16'h0002) == `IFW_W82_FIXED;
  endproperty
  a_w82: assert property (p_w82) else $error("word 82 fixed bits wrong");

  property p_w84;
    rd_ack && idx == `IFW_IDX_W84 |-> wb_dat_o[13:0] == 14'h0000;
  endproperty
  a_w84: assert property (p_w84) else $error("word 84 reserved bits set");

  property p_w87;
    rd_ack && idx == `IFW_IDX_W87 |-> wb_dat_o == 32'h0000_4000;
  endproperty
  a_w87: assert property (p_w87) else $error("word 87 wrong");

  property p_onehot;
    rd_ack && idx == `IFW_IDX_W88 |-> $onehot0(wb_dat_o[14:8])
                                   && !(wb_dat_o[14:8] != 7'h00 && $past(mwdma_selected_o));
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one DMA mode selected");

  property p_cum;
    udma_sup |-> ((w88[6:0] + 7'h01) & w88[6:0]) == 7'h00;
  endproperty
  a_cum: assert property (p_cum) else $error("supported modes not cumulative");

  property p_no_udma;
    !udma_sup |-> w88 == 16'h0000;
  endproperty
  a_no_udma: assert property (p_no_udma) else $error("word 88 nonzero without support");

  property p_expire;
    unlock_fail_limit_i |=> unlock_abort_o [*3];
  endproperty
  a_expire: assert property (p_expire) else $error("expiry not held");

  property p_level;
    rd_ack && idx == `IFW_IDX_W128 && !wb_dat_o[1] |-> !wb_dat_o[8];
  endproperty
  a_level: assert property (p_level) else $error("max level shown while disabled");

  property p_rot;
    rd_ack && idx == `IFW_IDX_W217 |-> wb_dat_o == 32'h0000_0001;
  endproperty
  a_rot: assert property (p_rot) else $error("rotation word wrong");

  property p_snap;
    assemble_i && !wr_ctrl |=> snap_ctrl == $past(ctrl);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not taken");

  property p_w83;
    rd_ack && idx == `IFW_IDX_W83 |-> (wb_dat_o[15:0] & 16'hFFF7) == `IFW_W83_FIXED;
  endproperty
  a_w83: assert property (p_w83) else $error("word 83 fixed bits wrong");

  property p_w85;
    rd_ack && idx == `IFW_IDX_W85 |-> (wb_dat_o[15:0] & 16'hFF9D) == `IFW_W85_FIXED;
  endproperty
  a_w85: assert property (p_w85) else $error("word 85 fixed bits wrong");

  property p_w86;
    rd_ack && idx == `IFW_IDX_W86 |-> (wb_dat_o[15:0] & 16'hFFF7) == `IFW_W86_FIXED;
  endproperty
  a_w86: assert property (p_w86) else $error("word 86 fixed bits wrong");

  property p_w88_rsv;
    rd_ack && idx == `IFW_IDX_W88 |-> !wb_dat_o[15] && !wb_dat_o[7];
  endproperty
  a_w88_rsv: assert property (p_w88_rsv) else $error("word 88 reserved bits set");

  property p_cap_top;
    rd_ack && idx == `IFW_IDX_W103 |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_cap_top: assert property (p_cap_top) else $error("capacity beyond 48 bits");

  property p_w128_rsv;
    rd_ack && idx == `IFW_IDX_W128 |-> wb_dat_o[15:9] == 7'h00 && wb_dat_o[7:6] == 2'b00;
  endproperty
  a_w128_rsv: assert property (p_w128_rsv) else $error("word 128 reserved bits set");

  property p_align;
    rd_ack && idx == `IFW_IDX_W209 && !$past(snap_ctrl[`IFW_CTRL_MULTI]) |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_align: assert property (p_align) else $error("alignment shown without multi flag");

  property p_qdepth;
    rd_ack && idx == `IFW_IDX_W75 |-> wb_dat_o[15:5] == 11'h000
                                   && ($past(snap_ctrl[`IFW_CTRL_QUEUE_SUP]) || wb_dat_o[4:0] == 5'h00);
  endproperty
  a_qdepth: assert property (p_qdepth) else $error("queue depth word wrong");

  property p_sticky;
    unlock_abort_o |=> unlock_abort_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("expiry cleared without reset");

  property p_upper;
    rd_ack && idx <= `IFW_IDX_W217 |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("identify word upper half not zero");

endmodule : ifw_feature_words

// ===== ifw_host_model.sv
// =====================================================================
// Host side bus master: classic single Wishbone cycles
module ifw_host_model (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [11:0]      wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 12'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // Request held until ack is sampled, then released
  task automatic xfer(input logic we, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_sel_o <= 4'hf;
    wb_dat_o <= wd;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= ~we;
    wb_sel_o <= 4'h0;
    // Released lines show a changed pattern, never the stale value
    wb_adr_o <= ~{idx, 2'b00};
    wb_dat_o <= ~wd;
  endtask : xfer

  function automatic bit informative(input logic [15:0] w);
    return (w !== 16'h0000) && (w !== 16'hffff);
  endfunction : informative
endmodule : ifw_host_model

// ===== identify_feature_words_test.sv
`include "ifw_defs.svh"
module identify_feature_words_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ifw_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, asm = 1'b0, flim = 1'b0, abort, mwdma;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr;
  int          errors = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'h263c_9692;
  logic [10:0] ctl, sctl;
  logic [4:0]  sec, ssec;
  logic [7:0]  dma, sdma;
  logic [15:0] erase, mpw;
  logic [47:0] lba;
  logic [13:0] aln;
  logic [4:0]  qd;
  logic [2:0]  mx;

  always #20 clk_i = ~clk_i;

  ifw_feature_words i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .assemble_i(asm),
    .unlock_fail_limit_i(flim), .unlock_abort_o(abort), .mwdma_selected_o(mwdma));
  ifw_host_model i_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(dr), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction : lfsr

  // Ultra selection only counts when legal and supported
  function automatic logic udma_ok();
    return sdma[6] && sctl[4] && (sdma[5:3] <= sdma[2:0]) && (sdma[5:3] != 3'd7);
  endfunction : udma_ok

  function automatic ifw_word_t exp_word(input int w);
    logic [48:0] s;
    logic [47:0] cap;
    logic [15:0] u;
    s = {1'b0, lba} + 49'd1;
    cap = s[48] ? 48'hffff_ffff_ffff : s[47:0];
    u = 16'((32'd2 << sdma[2:0]) - 32'd1);
    if (udma_ok()) begin
      u = u | 16'(32'd1 << (8 + sdma[5:3]));
    end
    case (w)
      75:  return sctl[9] ? {11'd0, qd} : 16'h0000;
      82:  return 16'h7408 | {9'd0, sctl[2], sctl[1], 3'd0, sctl[0], 1'b0};
      83:  return 16'h4001 | {12'd0, sctl[3], 3'd0};
      84:  return 16'h4000;
      85:  return 16'h7008 | {9'd0, sctl[7] & sctl[2], sctl[6] & sctl[1], 3'd0, ssec[0] & sctl[0], 1'b0};
      86:  return 16'h0001 | {12'd0, sctl[8] & sctl[3], 3'd0};
      87:  return 16'h4000;
      88:  return sctl[4] ? u : 16'h0000;
      89:  return erase;
      92:  return mpw;
      100: return cap[15:0];
      101: return cap[31:16];
      102: return cap[47:32];
      128: return {7'd0, ssec[3] & ssec[0] & sctl[0], 2'd0, sctl[5], ssec[4], ssec[2], ssec[1],
                   ssec[0] & sctl[0], sctl[0]};
      209: return sctl[10] ? {2'd0, aln} : 16'h0000;
      217: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction : exp_word

  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input int tag, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t item %0d got %h expected %h", $time, tag, got, exp);
    end
  endtask : cmp

  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] r);
    bit ok;
    i_host.xfer(w, idx, d, r, ok);
    if (!ok) begin
      errors++;
      $display("ERROR t=%0t no acknowledge", $time);
      stop_test();
    end
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0000_0000, r);
    cmp(int'(idx), r, exp);
  endtask : rd

  // Identify word read; feature words must also look informative to the host
  task automatic rdw(input int w);
    logic [31:0] r;
    xfer(1'b0, 10'(w), 32'h0000_0000, r);
    cmp(w, r, {16'h0000, exp_word(w)});
    if (w >= 82 && w <= 87) begin
      cmp(2, {31'd0, i_host.informative(r[15:0])}, 32'd1);
    end
  endtask : rdw

  // Model state after any reset
  task automatic model_reset();
    ctl = 11'h037;
    sec = 5'h00;
    dma = 8'h06;
    erase = 16'h0000;
    mpw = 16'hffff;
    lba = 48'h0000_0000_0000;
    aln = 14'h0000;
    qd = 5'h00;
    sctl = ctl;
    ssec = sec;
    sdma = dma;
  endtask : model_reset

  // Snapshot pulse; words follow from the next cycle
  task automatic assemble();
    @(posedge clk_i);
    asm <= 1'b1;
    @(posedge clk_i);
    asm <= 1'b0;
    sctl = ctl;
    ssec = sec;
    sdma = dma;
  endtask : assemble

  task automatic read_all();
    rdw(75);
    rdw(82);
    rdw(83);
    rdw(84);
    rdw(85);
    rdw(86);
    rdw(87);
    rdw(88);
    rdw(89);
    rdw(92);
    rdw(100);
    rdw(101);
    rdw(102);
    rdw(103);
    rdw(128);
    rdw(209);
    rdw(217);
    cmp(1, {31'd0, mwdma}, {31'd0, sdma[7] & ~udma_ok()});
  endtask : read_all

  initial begin
    model_reset();
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // =================================================================
    // Reset values of the configuration registers
    rd(`IFW_IDX_CTRL, 32'h0000_0037);
    rd(`IFW_IDX_SEC, 32'h0000_0000);
    rd(`IFW_IDX_DMA, 32'h0000_0006);
    rd(`IFW_IDX_MPWREV, 32'h0000_ffff);
    rd(`IFW_IDX_LBA_LO, 32'h0000_0000);
    cmp(3, {30'd0, abort, mwdma}, 32'd0);
    assemble();
    read_all();
    // =================================================================
    // Random configurations; every Ultra mode selected once
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      ctl = seed[10:0] | 11'h400;
      if (i < 8) ctl[4] = 1'b1;
      if (i == 8) ctl[4] = 1'b0;
      sec = {1'b0, seed[14:11]};
      mx = (i < 7) ? 3'(i + int'(seed[18:16]) % (7 - i)) : 3'(seed[18:16] % 7);
      dma = {seed[23], (i < 8) | seed[22], 3'(i % 8), mx};
      erase = seed[31:16];
      seed = lfsr(seed);
      mpw = seed[15:0];
      aln = seed[29:16];
      qd = seed[4:0];
      lba = (i == 0) ? 48'hffff_ffff_ffff : (i == 1) ? 48'hffff_ffff_fffe : {seed[31:16], lfsr(seed)};
      wr(`IFW_IDX_CTRL, {21'd0, ctl});
      wr(`IFW_IDX_SEC, {27'd0, sec});
      wr(`IFW_IDX_DMA, {24'd0, dma});
      wr(`IFW_IDX_ERASE, {16'd0, erase});
      wr(`IFW_IDX_MPWREV, {16'd0, mpw});
      wr(`IFW_IDX_LBA_LO, lba[31:0]);
      wr(`IFW_IDX_LBA_HI, {16'd0, lba[47:32]});
      wr(`IFW_IDX_ALIGN, {18'd0, aln});
      wr(`IFW_IDX_QDEPTH, {27'd0, qd});
      rd(`IFW_IDX_W85, {16'h0000, exp_word(85)});
      assemble();
      read_all();
    end
    // =================================================================
    // Unmapped place and read-only identify word
    wr(10'd300, 32'hffff_ffff);
    rd(10'd300, 32'h0000_0000);
    wr(`IFW_IDX_W82, 32'h0000_0000);
    rd(`IFW_IDX_W82, {16'h0000, exp_word(82)});
    // =================================================================
    // sticky expiry, cleared only by reset
    @(posedge clk_i);
    flim <= 1'b1;
    @(posedge clk_i);
    flim <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp(4, {31'd0, abort}, 32'd1);
    wr(`IFW_IDX_SEC, 32'h0000_0000);
    sec = 5'h10;
    rd(`IFW_IDX_SEC, 32'h0000_0010);
    assemble();
    rd(`IFW_IDX_W128, {16'h0000, exp_word(128)});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp(5, {31'd0, abort}, 32'd0);
    rd(`IFW_IDX_CTRL, 32'h0000_0037);
    // Snapshot and live words back at reset values
    model_reset();
    read_all();
    stop_test();
  end
endmodule : identify_feature_words_test
